// ---- sncp_pkg.sv ----
// constants and types shared by the serial nonvolatile memory control port
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
package sncp_pkg;

  // port decode: four addresses from the base
  localparam logic [7:0] SNCP_PORT_BASE   = 8'h28;
  localparam logic [7:0] SNCP_PORT_MASK   = 8'hFC;

  // latch field positions
  localparam int         SNCP_BIT_CLOCK   = 0;
  localparam int         SNCP_BIT_CMD_ONE = 1;
  localparam int         SNCP_BIT_CMD_TWO = 2;
  localparam int         SNCP_BIT_CMD_THR = 3;
  localparam int         SNCP_BIT_CMD_EN  = 4;
  localparam int         SNCP_BIT_PROG    = 5;
  localparam int         SNCP_BIT_DIR     = 6;
  localparam int         SNCP_BIT_DATA    = 7;

  // values after reset
  localparam logic [7:0] SNCP_LATCH_RESET = 8'h00;
  localparam logic       SNCP_CMD_STANDBY = 1'h1;
  localparam logic [7:0] SNCP_BUS_IDLE    = 8'h00;

  // handshake state of the latch crossing
  typedef enum logic [0:0] {
    SNCP_XFER_IDLE = 1'b0,
    SNCP_XFER_BUSY = 1'b1
  } sncp_xfer_state_t;

endpackage : sncp_pkg

// ---- sncp_word_xfer.sv ----
// handshake crossing of the latch word from the system clock to the link clock
module sncp_word_xfer
  import sncp_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_link,
  input  wire logic       rst_link,
  input  wire logic [7:0] word_in,
  output logic      [7:0] word_out
);

  sncp_xfer_state_t state_reg, state_next;
  logic [7:0] hold_reg, hold_next;
  logic       req_reg, req_next;
  logic       ack_s1_reg, ack_s2_reg;
  logic       req_s1_reg, req_s2_reg;
  logic       ack_reg, ack_next;
  logic [7:0] word_reg, word_next;

  ////////////////////////////////////////////////////////////////////////////
  // system side: launch a new word only when the previous one was taken
  always_comb begin
    state_next = state_reg;
    hold_next  = hold_reg;
    req_next   = req_reg;
    case (state_reg)
      SNCP_XFER_IDLE: begin
        if (word_in != hold_reg) begin
          hold_next  = word_in;
          req_next   = ~req_reg;
          state_next = SNCP_XFER_BUSY;
        end
      end
      SNCP_XFER_BUSY: begin
        if (ack_s2_reg == req_reg) begin
          state_next = SNCP_XFER_IDLE;
        end
      end
      default: state_next = SNCP_XFER_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg  <= SNCP_XFER_IDLE;
      hold_reg   <= SNCP_LATCH_RESET;
      req_reg    <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      hold_reg   <= hold_next;
      req_reg    <= req_next;
      ack_s1_reg <= ack_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side: take the held word when the request toggle arrives
  always_comb begin
    ack_next  = ack_reg;
    word_next = word_reg;
    if (req_s2_reg != ack_reg) begin
      word_next = hold_reg; // held stable while the request is open
      ack_next  = req_s2_reg;
    end
  end

  always_ff @(posedge clk_link) begin
    if (rst_link) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      ack_reg    <= 1'b0;
      word_reg   <= SNCP_LATCH_RESET;
    end else begin
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
      ack_reg    <= ack_next;
      word_reg   <= word_next;
    end
  end

  assign word_out = word_reg;

  // an open request is answered within a bounded number of system cycles
  property p_xfer_done;
    @(posedge clk_sys) disable iff (rst)
      $rose(state_reg == SNCP_XFER_BUSY) |-> ##[1:20] (state_reg == SNCP_XFER_IDLE);
  endproperty
  a_xfer_done: assert property (p_xfer_done) else $error("latch word not taken by link side");

endmodule : sncp_word_xfer

// ---- sncp_port.sv ----
// nonvolatile memory control port: I/O decode, write-only latch and memory pins
module sncp_port
  import sncp_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_link,
  input  wire logic [7:0] io_addr,
  input  wire logic [7:0] data_bus_in,
  input  wire logic       io_write_n,
  input  wire logic       io_read_n,
  output logic      [7:0] data_bus_out,
  output logic            data_bus_oe,
  output logic            nonvolatile_port_select_n,
  output logic            memory_clock,
  output logic            command_line_one,
  output logic            command_line_two,
  output logic            command_line_three,
  output logic            prog_voltage_en,
  input  wire logic       memory_data_in,
  output logic            memory_data_out,
  output logic            memory_data_oe,
  output logic            data_pullup_en
);

  // true for the four addresses of this port
  function automatic logic port_hit(input logic [7:0] addr);
    port_hit = (addr & SNCP_PORT_MASK) == SNCP_PORT_BASE;
  endfunction : port_hit

  logic [7:0] addr_s1_reg, addr_s2_reg;
  logic [7:0] data_s1_reg, data_s2_reg;
  logic       wr_s1_reg, wr_s2_reg, wr_prev_reg;
  logic       rd_s1_reg, rd_s2_reg;
  logic       mdata_s1_reg, mdata_s2_reg;
  logic [7:0] interface_control_latch_reg, interface_control_latch_next;
  logic [7:0] bus_out_reg, bus_out_next;
  logic       bus_oe_reg, bus_oe_next;
  logic       select_n_reg, select_n_next;
  logic       wr_end;
  logic       rd_hit;
  logic       rst_l1_reg, rst_l2_reg;
  logic [7:0] link_word;
  logic       clk_pin_reg, clk_pin_next;
  logic       cmd1_reg, cmd1_next;
  logic       cmd2_reg, cmd2_next;
  logic       cmd3_reg, cmd3_next;
  logic       prog_reg, prog_next;
  logic       dout_reg, dout_next;
  logic       doe_reg, doe_next;
  logic       pull_reg, pull_next;

  ////////////////////////////////////////////////////////////////////////////
  // bus pins arrive unsynchronised: two stages each
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_s1_reg  <= 8'h00;
      addr_s2_reg  <= 8'h00;
      data_s1_reg  <= 8'h00;
      data_s2_reg  <= 8'h00;
      wr_s1_reg    <= 1'b1;
      wr_s2_reg    <= 1'b1;
      wr_prev_reg  <= 1'b1;
      rd_s1_reg    <= 1'b1;
      rd_s2_reg    <= 1'b1;
      mdata_s1_reg <= 1'b0;
      mdata_s2_reg <= 1'b0;
    end else begin
      addr_s1_reg  <= io_addr;
      addr_s2_reg  <= addr_s1_reg;
      data_s1_reg  <= data_bus_in;
      data_s2_reg  <= data_s1_reg;
      wr_s1_reg    <= io_write_n;
      wr_s2_reg    <= wr_s1_reg;
      wr_prev_reg  <= wr_s2_reg;
      rd_s1_reg    <= io_read_n;
      rd_s2_reg    <= rd_s1_reg;
      mdata_s1_reg <= memory_data_in;
      mdata_s2_reg <= mdata_s1_reg;
    end
  end

  // write strobe trailing edge and read strobe on this port
  assign wr_end = wr_s2_reg & ~wr_prev_reg & port_hit(addr_s2_reg);
  assign rd_hit = ~rd_s2_reg & port_hit(addr_s2_reg);

  ////////////////////////////////////////////////////////////////////////////
  // latch, read-back and port select
  always_comb begin
    interface_control_latch_next = interface_control_latch_reg;
    if (wr_end) begin
      interface_control_latch_next = data_s2_reg;
    end
    bus_out_next  = SNCP_BUS_IDLE;
    bus_oe_next   = 1'b0;
    if (rd_hit) begin
      bus_out_next[SNCP_BIT_DATA] = mdata_s2_reg;
      bus_oe_next  = 1'b1;
    end
    select_n_next = ~((~wr_s2_reg | ~rd_s2_reg) & port_hit(addr_s2_reg));
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      interface_control_latch_reg <= SNCP_LATCH_RESET;
      bus_out_reg  <= SNCP_BUS_IDLE;
      bus_oe_reg   <= 1'b0;
      select_n_reg <= 1'b1;
    end else begin
      interface_control_latch_reg <= interface_control_latch_next;
      bus_out_reg  <= bus_out_next;
      bus_oe_reg   <= bus_oe_next;
      select_n_reg <= select_n_next;
    end
  end

  assign data_bus_out              = bus_out_reg;
  assign data_bus_oe               = bus_oe_reg;
  assign nonvolatile_port_select_n = select_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // reset carried into the link domain
  always_ff @(posedge clk_link) begin
    rst_l1_reg <= rst;
    rst_l2_reg <= rst_l1_reg;
  end

  // latch word into the link domain
  sncp_word_xfer u_xfer (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .clk_link (clk_link),
    .rst_link (rst_l2_reg),
    .word_in  (interface_control_latch_reg),
    .word_out (link_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // memory pins: pure decode of the latch, no sequencing of its own
  always_comb begin
    clk_pin_next = link_word[SNCP_BIT_CLOCK];
    cmd1_next    = ~link_word[SNCP_BIT_CMD_ONE];
    cmd2_next    = SNCP_CMD_STANDBY;
    cmd3_next    = SNCP_CMD_STANDBY;
    if (link_word[SNCP_BIT_CMD_EN]) begin
      cmd2_next  = link_word[SNCP_BIT_CMD_TWO];
      cmd3_next  = link_word[SNCP_BIT_CMD_THR];
    end
    prog_next    = link_word[SNCP_BIT_PROG];
    doe_next     = link_word[SNCP_BIT_DIR];
    pull_next    = link_word[SNCP_BIT_DIR];
    dout_next    = link_word[SNCP_BIT_DATA];
  end

  // standby commands and no voltage while reset
  always_ff @(posedge clk_link) begin
    if (rst_l2_reg) begin
      clk_pin_reg <= 1'b0;
      cmd1_reg    <= SNCP_CMD_STANDBY;
      cmd2_reg    <= SNCP_CMD_STANDBY;
      cmd3_reg    <= SNCP_CMD_STANDBY;
      prog_reg    <= 1'b0;
      dout_reg    <= 1'b0;
      doe_reg     <= 1'b0;
      pull_reg    <= 1'b0;
    end else begin
      clk_pin_reg <= clk_pin_next;
      cmd1_reg    <= cmd1_next;
      cmd2_reg    <= cmd2_next;
      cmd3_reg    <= cmd3_next;
      prog_reg    <= prog_next;
      dout_reg    <= dout_next;
      doe_reg     <= doe_next;
      pull_reg    <= pull_next;
    end
  end

  // memory lines: clock, three commands, programming voltage, and one data line with its enable and pull-up
  assign memory_clock       = clk_pin_reg;
  assign command_line_one   = cmd1_reg;
  assign command_line_two   = cmd2_reg;
  assign command_line_three = cmd3_reg;
  assign prog_voltage_en    = prog_reg;
  assign memory_data_out    = dout_reg;
  assign memory_data_oe     = doe_reg;
  assign data_pullup_en     = pull_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the system side
  property p_write_capture;
    @(posedge clk_sys) disable iff (rst)
      wr_end |=> (interface_control_latch_reg == $past(data_s2_reg));
  endproperty
  a_write_capture: assert property (p_write_capture) else $error("latch missed port write");

  property p_other_port;
    @(posedge clk_sys) disable iff (rst)
      (wr_s2_reg && !wr_prev_reg && !port_hit(addr_s2_reg)) |=> $stable(interface_control_latch_reg);
  endproperty
  a_other_port: assert property (p_other_port) else $error("latch written from foreign address");

  property p_reset_clear;
    @(posedge clk_sys) disable iff (rst)
      $fell(rst) |-> (interface_control_latch_reg == SNCP_LATCH_RESET);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("latch not cleared by reset");

  property p_read_back;
    @(posedge clk_sys) disable iff (rst)
      rd_hit |=> bus_oe_reg && (bus_out_reg == {$past(mdata_s2_reg), 7'h00});
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data not on bit 7");

  property p_select;
    @(posedge clk_sys) disable iff (rst)
      (!wr_s2_reg && port_hit(addr_s2_reg)) |=> !select_n_reg ##1 1'b1;
  endproperty
  a_select: assert property (p_select) else $error("port select missing on write");

  ////////////////////////////////////////////////////////////////////////////
  // checks on the memory pins
  property p_cmd_one;
    @(posedge clk_link) disable iff (rst_l2_reg)
      $past(!rst_l2_reg) |-> (cmd1_reg == !$past(link_word[SNCP_BIT_CMD_ONE]));
  endproperty
  a_cmd_one: assert property (p_cmd_one) else $error("first command line not inverted");

  property p_cmd_two;
    @(posedge clk_link) disable iff (rst_l2_reg)
      link_word[SNCP_BIT_CMD_EN] |=> (cmd2_reg == $past(link_word[SNCP_BIT_CMD_TWO]));
  endproperty
  a_cmd_two: assert property (p_cmd_two) else $error("second command line not following");

  property p_cmd_three;
    @(posedge clk_link) disable iff (rst_l2_reg)
      link_word[SNCP_BIT_CMD_EN] |=> (cmd3_reg == $past(link_word[SNCP_BIT_CMD_THR]));
  endproperty
  a_cmd_three: assert property (p_cmd_three) else $error("third command line not following");

  property p_cmd_forced;
    @(posedge clk_link) disable iff (rst_l2_reg)
      !link_word[SNCP_BIT_CMD_EN] |=> cmd2_reg && cmd3_reg;
  endproperty
  a_cmd_forced: assert property (p_cmd_forced) else $error("command lines not forced high");

  property p_standby_clear;
    @(posedge clk_link) disable iff (rst_l2_reg)
      (link_word == SNCP_LATCH_RESET)[*2] |-> cmd1_reg && cmd2_reg && cmd3_reg && !prog_reg;
  endproperty
  a_standby_clear: assert property (p_standby_clear) else $error("cleared latch not standby");

  property p_prog;
    @(posedge clk_link) disable iff (rst_l2_reg)
      $rose(link_word[SNCP_BIT_PROG]) |=> prog_reg;
  endproperty
  a_prog: assert property (p_prog) else $error("programming voltage not enabled");

  property p_direction;
    @(posedge clk_link) disable iff (rst_l2_reg)
      $past(!rst_l2_reg) |-> (doe_reg == pull_reg) && (doe_reg == $past(link_word[SNCP_BIT_DIR]));
  endproperty
  a_direction: assert property (p_direction) else $error("buffer and pull-up disagree");

  property p_data_out;
    @(posedge clk_link) disable iff (rst_l2_reg)
      link_word[SNCP_BIT_DIR] |=> memory_data_oe && (dout_reg == $past(link_word[SNCP_BIT_DATA]));
  endproperty
  a_data_out: assert property (p_data_out) else $error("data pin not driven from bit 7");

endmodule : sncp_port

// ---- sncp_mem_model.sv ----
// behavioural serial memory standing on the far side of the control port
module sncp_mem_model #(
  parameter logic [15:0] WORD = 16'hA5C3
) (
  input  wire logic memory_clock,
  input  wire logic command_line_one,
  input  wire logic command_line_two,
  input  wire logic command_line_three,
  input  wire logic host_data,
  input  wire logic host_oe,
  output logic      data_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] bit_cnt;
  logic       last_host;
  logic       standby;
  ////////////////////////////////////////////////////////////////////////////////
  // all three command lines high means standby
  assign standby = command_line_one & command_line_two & command_line_three;
  // bit position advances on each clock rise while a command is open
  initial bit_cnt = 4'h0;
  always @(posedge memory_clock or posedge standby) begin
    if (standby) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end
  // remember what the host drove last, so a released line in standby never shows it
  initial last_host = 1'b0;
  always @(host_data or host_oe) begin
    if (host_oe) begin
      last_host = host_data;
    end
  end
  // host drives when outbound, memory answers when a command is open
  assign data_wire = host_oe ? host_data : (!standby ? WORD[bit_cnt] : ~last_host);
endmodule : sncp_mem_model

// ---- sncp_port_tb_top.sv ----
// self-checking bench of the nonvolatile memory control port
module sncp_port_tb_top import sncp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] MEM_WORD = 16'hA5C3;
  localparam int          LIMIT    = 20000;
  localparam logic [7:0]  VALS [8] = '{8'h10, 8'h1C, 8'h0C, 8'h02, 8'h21, 8'hC0, 8'h40, 8'h9A};
  logic       clk_sys;
  logic       clk_link;
  logic       rst;
  logic [7:0] io_addr;
  logic [7:0] data_bus_in;
  logic       io_write_n;
  logic       io_read_n;
  logic [7:0] data_bus_out;
  logic       data_bus_oe;
  logic       nonvolatile_port_select_n;
  logic       memory_clock;
  logic       command_line_one;
  logic       command_line_two;
  logic       command_line_three;
  logic       prog_voltage_en;
  logic       memory_data_in;
  logic       memory_data_out;
  logic       memory_data_oe;
  logic       data_pullup_en;
  logic [7:0] pins;
  int         num_errors;
  int         n_tests;
  int         cycles;
  ////////////////////////////////////////////////////////////////////////////////
  // clocks: system 50 ns, link 80 ns with unrelated phase
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #13;
    forever #40 clk_link = ~clk_link;
  end
  sncp_port u_dut (
    .clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .io_addr(io_addr),
    .data_bus_in(data_bus_in), .io_write_n(io_write_n), .io_read_n(io_read_n),
    .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
    .nonvolatile_port_select_n(nonvolatile_port_select_n), .memory_clock(memory_clock),
    .command_line_one(command_line_one), .command_line_two(command_line_two),
    .command_line_three(command_line_three), .prog_voltage_en(prog_voltage_en),
    .memory_data_in(memory_data_in), .memory_data_out(memory_data_out),
    .memory_data_oe(memory_data_oe), .data_pullup_en(data_pullup_en)
  );
  sncp_mem_model #(.WORD(MEM_WORD)) u_mem (
    .memory_clock(memory_clock), .command_line_one(command_line_one),
    .command_line_two(command_line_two), .command_line_three(command_line_three),
    .host_data(memory_data_out), .host_oe(memory_data_oe), .data_wire(memory_data_in)
  );
  // memory pins gathered for one comparison
  assign pins = {memory_clock, command_line_one, command_line_two, command_line_three,
                 prog_voltage_en, memory_data_out, memory_data_oe, data_pullup_en};
  ////////////////////////////////////////////////////////////////////////////////
  // expected pins for a latch value
  function automatic logic [7:0] exp_pins(input logic [7:0] v);
    return {v[0], ~v[1], v[4] ? v[2] : 1'b1, v[4] ? v[3] : 1'b1, v[5], v[7], v[6], v[6]};
  endfunction : exp_pins
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic end_of_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  // one I/O write, strobe and hold times of several cycles each
  task automatic io_write(input logic [7:0] a, input logic [7:0] d);
    logic hit;
    hit = (a & SNCP_PORT_MASK) == SNCP_PORT_BASE;
    @(posedge clk_sys);
    io_addr     <= a;
    data_bus_in <= d;
    io_write_n  <= 1'b0;
    tick(5);
    check("port_select_n", {7'h0, ~hit}, {7'h0, nonvolatile_port_select_n});
    @(posedge clk_sys);
    io_write_n <= 1'b1;
    tick(5);
  endtask : io_write
  // one I/O read, data taken while the strobe still stands
  task automatic io_read(input logic [7:0] a, output logic [7:0] d, output logic oe);
    logic hit;
    hit = (a & SNCP_PORT_MASK) == SNCP_PORT_BASE;
    @(posedge clk_sys);
    io_addr   <= a;
    io_read_n <= 1'b0;
    tick(6);
    d  = data_bus_out;
    oe = data_bus_oe;
    check("read_select_n", {7'h0, ~hit}, {7'h0, nonvolatile_port_select_n});
    @(posedge clk_sys);
    io_read_n <= 1'b1;
    tick(5);
  endtask : io_read
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check("pins_reset", exp_pins(SNCP_LATCH_RESET), pins);
    check("bus_oe_select_n", 8'h01, {6'h0, data_bus_oe, nonvolatile_port_select_n});
  endtask : test_reset
  // every field through each of the four addresses
  task automatic test_fields();
    for (int i = 0; i < 8; i++) begin
      io_write(SNCP_PORT_BASE + 8'(i % 4), VALS[i]);
      // long enough that a raised memory clock keeps its minimum high time
      tick(100);
      check("pins", exp_pins(VALS[i]), pins);
    end
  endtask : test_fields
  // neighbouring addresses neither load nor answer
  task automatic test_unmapped();
    logic [7:0] d;
    logic       oe;
    io_write(8'h2C, 8'h55);
    io_write(8'h27, 8'h55);
    tick(30);
    check("pins_unmapped", exp_pins(VALS[7]), pins);
    io_read(8'h2C, d, oe);
    check("read_oe_unmapped", 8'h00, {7'h0, oe});
  endtask : test_unmapped
  // clock bits out of the memory and read them on bus bit 7
  task automatic test_read();
    logic [7:0] d;
    logic       oe;
    io_write(SNCP_PORT_BASE, 8'h10);
    tick(30);
    for (int i = 0; i < 3; i++) begin
      io_read(SNCP_PORT_BASE + 8'h3, d, oe);
      check("read_data", {MEM_WORD[i], 7'h0}, d);
      check("read_oe", 8'h01, {7'h0, oe});
      io_write(SNCP_PORT_BASE, 8'h11);
      tick(120);
      io_write(SNCP_PORT_BASE, 8'h10);
      tick(120);
    end
  endtask : test_read
  ////////////////////////////////////////////////////////////////////////////////
  // cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles >= LIMIT) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    rst         = 1'b1;
    io_addr     = 8'h00;
    data_bus_in = 8'h00;
    io_write_n  = 1'b1;
    io_read_n   = 1'b1;
    num_errors  = 0;
    n_tests     = 0;
    cycles      = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    tick(2);
    test_reset();
    test_fields();
    test_unmapped();
    test_read();
    end_of_test();
  end
endmodule : sncp_port_tb_top
